// ### dv/asf_host_model.sv
module asf_host_model (
  output logic csN,
  output logic sclk,
  output logic din,
  input wire logic dout,
  input wire logic doutOeN
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] txq [8];
  logic [31:0] rxq [8];
  // Clock idles low and runs inside frames and, deselected, in idle
  initial begin
    csN = 1'b1;
    sclk = 1'b0;
    din = 1'b1;
  end
  // Whole frame, or cut after a bit count to model an abort
  task automatic frame(input int nw, input int nb, input int cut);
    int tot;
    tot = (cut != 0) ? cut : nw * nb;
    foreach (rxq[i]) rxq[i] = '0;
    csN = 1'b0;
    #150;
    for (int n = 0; n < tot; n++) begin
      sclk = 1'b1;
      din = txq[n / nb][nb - 1 - n % nb];
      #15;
      sclk = 1'b0;
      // A released output reads back inverted, so a missing enable shows up
      rxq[n / nb][nb - 1 - n % nb] = (doutOeN === 1'b0) ? dout : ~dout;
      #15;
    end
    csN = 1'b1;
    din = ~din; // Released line shows no stale bit
    #200;
  endtask
  // Clocking while deselected must be ignored
  task automatic idle(input int n);
    repeat (n) begin
      sclk = 1'b1;
      #15;
      sclk = 1'b0;
      #15;
    end
  endtask
endmodule

// ### dv/asf_spi_top_props.sv
module asf_spi_top_props (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic csN,
  input wire logic dout,
  input wire logic doutOeN,
  input wire logic dataReadyN,
  input wire logic dataReadyOeN,
  input wire logic [1:0] readySourceSelect,
  input wire logic readyIdleFloat,
  input wire logic readyPulseFormat,
  input wire logic globalChop,
  input wire logic [asf_pkg::NUM_CH-1:0] chanEnable,
  input wire logic [asf_pkg::NUM_CH-1:0] chanNewData,
  input wire logic [asf_pkg::NUM_CH-1:0][asf_pkg::PHASE_W-1:0] channelPhaseCal,
  input wire logic rxValid,
  input wire logic frameActive
);
  timeunit 1ns;
  timeprecision 1ps;
  import asf_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // Short pulse: two low cycles, then released
  sequence short_pulse_s;
    !dataReadyN [*2] ##1 dataReadyN;
  endsequence
  // Phases above the highest boundary can never defer the first ready
  sequence no_defer_s;
    $signed(channelPhaseCal[0]) > $signed(BOUND_128) && $signed(channelPhaseCal[1]) > $signed(BOUND_128);
  endsequence
  ////////////////////////////////////////////////////////////////////////
  a_oe_follows_cs: assert property (doutOeN == csN)
    else $error("serial out enable differs from chip select");
  a_dout_idle_zero: assert property (csN |-> !dout)
    else $error("serial out not cleared while deselected");
  a_frame_closes: assert property ($rose(csN) |-> ##[1:4] !frameActive)
    else $error("frame not closed after deselect");
  a_frame_opens: assert property ($fell(csN) |-> ##[1:4] frameActive)
    else $error("frame not opened after select");
  a_ready_driven: assert property (!dataReadyN |-> !dataReadyOeN)
    else $error("ready low but not driven");
  a_float_release: assert property (readyIdleFloat && $past(readyIdleFloat) && dataReadyN && $past(dataReadyN)
    |-> dataReadyOeN)
    else $error("ready idle still driven in float mode");
  a_push_pull: assert property (!readyIdleFloat && !$past(readyIdleFloat) |-> !dataReadyOeN)
    else $error("ready not driven in push-pull mode");
  a_any_source: assert property (!readyPulseFormat && !globalChop && readySourceSelect == SRC_ANY
    && (chanNewData & chanEnable) != '0 ##0 no_defer_s |-> ##[1:3] !dataReadyN)
    else $error("ready missed a channel result");
  a_pulse_width: assert property (readyPulseFormat && $past(readyPulseFormat) && $fell(dataReadyN)
    |-> short_pulse_s)
    else $error("ready pulse width wrong");
  a_rx_single: assert property (rxValid |=> !rxValid [*8])
    else $error("received word strobe too long");
endmodule
bind asf_spi_top asf_spi_top_props u_props (.*);

// ### dv/tb_adc_spi_frame_and_ready_logic.sv
`define CHK(a, e) chk((a) === (e), 64'(a), 64'(e))
module tb_adc_spi_frame_and_ready_logic;
  timeunit 1ns;
  timeprecision 1ps;
  import asf_pkg::*;
  logic core_clk = 1'b0, nrst = 1'b0, sclk, csN, din, dout, doutOeN, dataReadyN, dataReadyOeN;
  logic [1:0] wordLengthSel = WLEN_24, readySourceSelect = SRC_ANY;
  logic readyIdleFloat = 1'b0, readyPulseFormat = 1'b0, globalChop = 1'b0, syncPulse = 1'b0;
  logic [2:0] oversamplingRatio = OSR_128;
  logic [NUM_CH-1:0] chanEnable = 2'h3, chanNewData = 2'h0;
  logic [NUM_CH-1:0][ADC_W-1:0] chanData = {24'h8A1B2C, 24'h3D4E5F};
  logic [NUM_CH-1:0][PHASE_W-1:0] channelPhaseCal = {10'h3FD, 10'h005};
  logic [CMD_W-1:0] respWord = 16'hB00C, outCheckWord = 16'hC4EC, rxWord;
  logic [EXTRA_CNT_W-1:0] respExtraCount = 3'h0;
  logic [MAX_EXTRA-1:0][CMD_W-1:0] respExtraWords = {16'h4444, 16'h3333, 16'h2222, 16'h1111};
  logic [WORD_IDX_W-1:0] rxWordIndex, rxI [16];
  logic [CMD_W-1:0] rxW [16];
  logic rxValid, frameActive;
  logic [9:0] bnd [5] = '{10'h3ED, 10'h3AD, 10'h32D, 10'h22D, 10'h200};
  int miscompares = 0, nChecks = 0, rxN = 0, lowCnt;
  asf_spi_top DUT (.*);
  asf_host_model host (.*);
  // 25 MHz core clock
  always #20 core_clk = ~core_clk;
  // Collect every received word, sampled where it has settled
  always @(negedge core_clk) if (rxValid === 1'b1 && rxN < 16) begin
    rxW[rxN] = rxWord;
    rxI[rxN] = rxWordIndex;
    rxN++;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input bit ok, input logic [63:0] g, input logic [63:0] e);
    nChecks++;
    if (!ok) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%0h exp=%0h", $time, g, e);
    end
  endtask
  // Short words sit at the top of the word, left-aligned here
  function automatic logic [31:0] sw(input logic [15:0] w, input int nb);
    return 32'(w) << (nb - 16);
  endfunction
  function automatic logic [31:0] chw(input logic [23:0] d, input int wl);
    case (wl)
      0: return 32'(d[23:8]);
      1: return 32'(d);
      2: return {d, 8'h00};
      default: return {{8{d[23]}}, d};
    endcase
  endfunction
  // Full frame with ex register words after the response
  task automatic run(input int wl, input int ex);
    int nb, nw;
    nb = (wl == 0) ? 16 : (wl == 1) ? 24 : 32;
    nw = ex + 4;
    @(negedge core_clk);
    wordLengthSel = 2'(wl);
    respExtraCount = 3'(ex);
    rxN = 0;
    host.txq[0] = sw(16'hC35A, nb);
    // Plain frames: check word, then zeros; longer frames carry register data
    for (int i = 1; i < 8; i++) host.txq[i] = (ex == 0 && i > 1) ? 32'h0 : sw(16'(i * 16'h1111), nb);
    host.frame(nw, nb, 0);
    repeat (6) @(negedge core_clk);
    `CHK(host.rxq[0], sw(respWord, nb));
    for (int i = 0; i < ex; i++) `CHK(host.rxq[1 + i], sw(respExtraWords[i], nb));
    for (int c = 0; c < 2; c++) `CHK(host.rxq[ex + 1 + c], chanEnable[c] ? chw(chanData[c], wl) : 32'h0);
    `CHK(host.rxq[ex + 3], sw(outCheckWord, nb));
    `CHK(rxN, nw);
    `CHK(rxW[0], 16'hC35A);
    `CHK(rxW[1], 16'h1111);
    `CHK(rxI[nw - 1], 8'(nw - 1));
    `CHK(rxW[nw - 1], (ex == 0) ? 16'h0000 : 16'((nw - 1) * 16'h1111));
  endtask
  // One result pulse, then count low cycles over n samples
  task automatic fire(input logic [1:0] m, input int n);
    @(negedge core_clk);
    chanNewData = m;
    lowCnt = 0;
    repeat (n) begin
      @(negedge core_clk);
      chanNewData = 2'h0;
      lowCnt += (dataReadyN === 1'b0);
    end
  endtask
  // Level format: expect ready or not, and clear it by reading a frame
  task automatic ev(input logic [1:0] m, input bit low);
    fire(m, 4);
    `CHK(dataReadyN, !low);
    `CHK(dataReadyOeN, low ? 1'b0 : readyIdleFloat);
    if (low) begin
      run(0, 0);
      `CHK(dataReadyN, 1'b1);
    end
  endtask
  task automatic sync();
    @(negedge core_clk);
    syncPulse = 1'b1;
    @(negedge core_clk);
    syncPulse = 1'b0;
  endtask
  task automatic summarize();
    $display("checks=%0d mismatches=%0d", nChecks, miscompares);
    if (miscompares == 0 && nChecks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Hang guard, well above the expected run time
  initial begin
    #1ms;
    miscompares++;
    summarize();
  end
  initial begin
    repeat (5) @(negedge core_clk);
    nrst = 1'b1;
    repeat (4) @(negedge core_clk);
    `CHK(dataReadyN, 1'b1);
    `CHK(dataReadyOeN, 1'b0);
    `CHK(doutOeN, 1'b1);
    $display("test reset done");
    for (int wl = 0; wl < 4; wl++) run(wl, 0);
    chanEnable = 2'h1;
    run(1, 0);
    chanEnable = 2'h3;
    run(2, 2);
    run(1, 4);
    // Frames are cut only with the converters off, as the host must
    chanEnable = 2'h0;
    rxN = 0;
    host.idle(20);
    host.frame(4, 24, 10);
    `CHK(rxN, 0);
    @(negedge core_clk);
    chanEnable = 2'h3;
    run(1, 0);
    $display("test frames done");
    // Ch0 lags (+5), ch1 leads (-3)
    for (int s = 0; s < 4; s++) begin
      readySourceSelect = 2'(s);
      ev(2'h1, s < 2);
      ev(2'h2, s != 0);
    end
    globalChop = 1'b1;
    readySourceSelect = SRC_LAGGING;
    ev(2'h2, 1'b1);
    globalChop = 1'b0;
    readySourceSelect = 2'h2;
    for (int o = 0; o < 5; o++) begin
      oversamplingRatio = 3'(o);
      channelPhaseCal[1] = bnd[o];
      sync();
      ev(2'h2, o == 4);
      ev(2'h2, 1'b1);
      channelPhaseCal[1] = bnd[o] + 10'h001;
      sync();
      ev(2'h2, 1'b1);
    end
    $display("test ready source done");
    readyIdleFloat = 1'b1;
    ev(2'h2, 1'b1);
    fire(2'h2, 4);
    fire(2'h2, 4);
    `CHK(lowCnt, 3);
    `CHK(dataReadyN, 1'b0);
    run(0, 0);
    readyPulseFormat = 1'b1;
    fire(2'h2, 6);
    `CHK(lowCnt, READY_PULSE_CYC);
    fire(2'h2, 6);
    `CHK(lowCnt, 0);
    fire(2'h2, 6);
    `CHK(lowCnt, READY_PULSE_CYC);
    run(0, 0);
    fire(2'h2, 6);
    `CHK(lowCnt, READY_PULSE_CYC);
    $display("test ready format done");
    summarize();
  end
endmodule

// ### hdl/asf_pkg.sv
package asf_pkg;
  // Channel and word geometry
  localparam int NUM_CH = 2;
  localparam int ADC_W = 24;
  localparam int CMD_W = 16;
  localparam int PHASE_W = 10;
  localparam int MAX_EXTRA = 4;
  localparam int EXTRA_CNT_W = 3;
  localparam int EXTRA_IDX_W = 2;
  localparam int WORD_IDX_W = 8;
  localparam int BIT_CNT_W = 6;
  localparam int PULSE_CNT_W = 3;

  // Word length select codes
  localparam logic [1:0] WLEN_16 = 2'h0;
  localparam logic [1:0] WLEN_24 = 2'h1;
  localparam logic [1:0] WLEN_32_ZERO = 2'h2;
  localparam logic [1:0] WLEN_32_SIGN = 2'h3;
  localparam logic [BIT_CNT_W-1:0] BITS_16 = 6'h10;
  localparam logic [BIT_CNT_W-1:0] BITS_24 = 6'h18;
  localparam logic [BIT_CNT_W-1:0] BITS_32 = 6'h20;

  // Ready source select codes; any other code picks the leading channel
  localparam logic [1:0] SRC_LAGGING = 2'h0;
  localparam logic [1:0] SRC_ANY = 2'h1;

  // Oversampling ratio codes and first-ready phase boundaries
  localparam logic [2:0] OSR_128 = 3'h0;
  localparam logic [2:0] OSR_256 = 3'h1;
  localparam logic [2:0] OSR_512 = 3'h2;
  localparam logic [2:0] OSR_1024 = 3'h3;
  localparam logic [PHASE_W-1:0] BOUND_128 = 10'h3ED;
  localparam logic [PHASE_W-1:0] BOUND_256 = 10'h3AD;
  localparam logic [PHASE_W-1:0] BOUND_512 = 10'h32D;
  localparam logic [PHASE_W-1:0] BOUND_1024 = 10'h22D;

  // Timing: short ready pulse, least time rounded up
  localparam int CORE_CLK_NS = 40;
  localparam int READY_PULSE_NS = 80;
  localparam int READY_PULSE_CYC = (READY_PULSE_NS + CORE_CLK_NS - 1) / CORE_CLK_NS;

  typedef enum logic [3:0] {
    RDY_HIGH = 4'h1,
    RDY_LOW = 4'h2,
    RDY_BLIP = 4'h4,
    RDY_PULSE = 4'h8
  } asf_ready_state_e;
endpackage

// ### hdl/asf_ready_gen.sv
module asf_ready_gen (
  input wire logic core_clk,
  input wire logic nrst,
  asf_ready_if.gen rdy
);
  import asf_pkg::*;

  asf_ready_state_e state_q, state_d;
  logic [PULSE_CNT_W-1:0] pulseCnt_q, pulseCnt_d;
  logic unread_q, unread_d;
  logic firstPend_q, firstPend_d;
  logic [NUM_CH-1:0] enPrev_q;
  logic readyN_q, readyN_d;
  logic oeN_q, oeN_d;
  logic lagIdx, leadIdx, selEvt, hasBound, skipFirst, evt;
  logic [PHASE_W-1:0] ctrlPhase, bound;

  ////////////////////////////////////////////////////////////////////////////
  // Source channel selection; ties favour channel 0
  always_comb begin
    lagIdx = $signed(rdy.chanPhase[1]) > $signed(rdy.chanPhase[0]);
    leadIdx = $signed(rdy.chanPhase[1]) < $signed(rdy.chanPhase[0]);
    ctrlPhase = rdy.chanPhase[leadIdx];
    if (rdy.globalChop) begin
      selEvt = |(rdy.chanNewData & rdy.chanEnable);
    end else if (rdy.sourceSel == SRC_LAGGING) begin
      selEvt = rdy.chanNewData[lagIdx];
      ctrlPhase = rdy.chanPhase[lagIdx];
    end else if (rdy.sourceSel == SRC_ANY) begin
      selEvt = |rdy.chanNewData;
    end else begin
      selEvt = rdy.chanNewData[leadIdx];
    end
  end

  // First-ready boundary per ratio; large ratios never defer
  always_comb begin
    hasBound = 1'b1;
    unique case (rdy.osrSel)
      OSR_128: bound = BOUND_128;
      OSR_256: bound = BOUND_256;
      OSR_512: bound = BOUND_512;
      OSR_1024: bound = BOUND_1024;
      default: begin
        bound = BOUND_1024;
        hasBound = 1'b0;
      end
    endcase
    skipFirst = !rdy.globalChop && hasBound && ($signed(ctrlPhase) <= $signed(bound));
    evt = selEvt && !(firstPend_q && skipFirst);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Ready state machine; level format gives one falling edge per selected result
  always_comb begin
    state_d = state_q;
    pulseCnt_d = pulseCnt_q;
    unread_d = unread_q;
    firstPend_d = firstPend_q;
    if (selEvt) begin
      firstPend_d = 1'b0;
    end
    // Set wins over the clear in the same cycle
    if (rdy.syncPulse || |(rdy.chanEnable & ~enPrev_q)) begin
      firstPend_d = 1'b1;
    end
    if (rdy.readDone) begin
      unread_d = 1'b0;
    end
    unique case (state_q)
      RDY_HIGH: begin
        if (evt && rdy.pulseFormat) begin
          // A read landing in the same cycle counts, so that event still pulses
          if (unread_q && !rdy.readDone) begin
            unread_d = 1'b0;
          end else begin
            state_d = RDY_PULSE;
            pulseCnt_d = PULSE_CNT_W'(READY_PULSE_CYC - 1);
            unread_d = 1'b1;
          end
        end else if (evt) begin
          state_d = RDY_LOW;
        end
      end
      RDY_LOW: begin
        if (evt) begin
          state_d = RDY_BLIP;
        end else if (rdy.readDone) begin
          state_d = RDY_HIGH;
        end
      end
      RDY_BLIP: state_d = RDY_LOW;
      RDY_PULSE: begin
        if (pulseCnt_q == '0) begin
          state_d = RDY_HIGH;
        end else begin
          pulseCnt_d = pulseCnt_q - 1'b1;
        end
      end
    endcase
    readyN_d = !((state_d == RDY_LOW) || (state_d == RDY_PULSE));
    oeN_d = rdy.idleFloat && readyN_d;
  end

  // Outputs registered so the pin never glitches
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= RDY_HIGH;
      pulseCnt_q <= '0;
      unread_q <= 1'b0;
      firstPend_q <= 1'b1;
      enPrev_q <= '0;
      readyN_q <= 1'b1;
      oeN_q <= 1'b0;
    end else begin
      state_q <= state_d;
      pulseCnt_q <= pulseCnt_d;
      unread_q <= unread_d;
      firstPend_q <= firstPend_d;
      enPrev_q <= rdy.chanEnable;
      readyN_q <= readyN_d;
      oeN_q <= oeN_d;
    end
  end

  assign rdy.readyN = readyN_q;
  assign rdy.readyOeN = oeN_q;
endmodule

// ### hdl/asf_ready_if.sv
interface asf_ready_if;
  import asf_pkg::*;
  logic [NUM_CH-1:0] chanNewData;
  logic [NUM_CH-1:0] chanEnable;
  logic [NUM_CH-1:0][PHASE_W-1:0] chanPhase;
  logic [2:0] osrSel;
  logic globalChop;
  logic syncPulse;
  logic [1:0] sourceSel;
  logic idleFloat;
  logic pulseFormat;
  logic readDone;
  logic readyN;
  logic readyOeN;
  modport core (output chanNewData, chanEnable, chanPhase, osrSel, globalChop, syncPulse, sourceSel,
    idleFloat, pulseFormat, readDone, input readyN, readyOeN);
  modport gen (input chanNewData, chanEnable, chanPhase, osrSel, globalChop, syncPulse, sourceSel,
    idleFloat, pulseFormat, readDone, output readyN, readyOeN);
endinterface

// ### hdl/asf_spi_top.sv
// Overview of operation
// - Chip select high: ignore serial traffic, release serial output.
// - Rising chip select resets the serial logic; next low starts fresh.
// - Output changes on rising clock, input sampled on falling clock.
// - Ready falls once per data period when new results exist.
// - Select 00: ready follows the most lagging channel.
// - Select 01: ready on every channel result.
// - Select 10 or 11: ready follows the most leading channel.
// - Global chop: source select has no effect on ready.
// - After enable or sync, negative phase may bring first ready early.
// - Phase at or below boundary defers first ready one period; never under global chop.
// - Ratio 1024 boundary 22D; above 1024 never deferred.
// - Idle float 0: drive high; 1: open drain, low only.
// - Level format: low until data read, or brief high before next.
// - Pulse format: short pulse; unread pulse drops the next result.
// - Word lengths 16, 24 or 32 bits, same for every word.
// - Frame starts with command; first output is previous response.
// - Output: response, two channel words, check word.
// - Disabled channels keep their slot and read zero.
// - Register read: acknowledge then register words, frame lengthens.
// - Register write: every extra input word is accepted.
// - Clock idles low, mode with phase 1.
// - Sixteen-bit words sit at the top, low bits zero.
// - Check word always ends the output frame.
module asf_spi_top (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic sclk,
  input wire logic csN,
  input wire logic din,
  output logic dout,
  output logic doutOeN,
  output logic dataReadyN,
  output logic dataReadyOeN,
  input wire logic [1:0] wordLengthSel,
  input wire logic [1:0] readySourceSelect,
  input wire logic readyIdleFloat,
  input wire logic readyPulseFormat,
  input wire logic globalChop,
  input wire logic [2:0] oversamplingRatio,
  input wire logic syncPulse,
  input wire logic [asf_pkg::NUM_CH-1:0] chanEnable,
  input wire logic [asf_pkg::NUM_CH-1:0] chanNewData,
  input wire logic [asf_pkg::NUM_CH-1:0][asf_pkg::ADC_W-1:0] chanData,
  input wire logic [asf_pkg::NUM_CH-1:0][asf_pkg::PHASE_W-1:0] channelPhaseCal,
  input wire logic [asf_pkg::CMD_W-1:0] respWord,
  input wire logic [asf_pkg::EXTRA_CNT_W-1:0] respExtraCount,
  input wire logic [asf_pkg::MAX_EXTRA-1:0][asf_pkg::CMD_W-1:0] respExtraWords,
  input wire logic [asf_pkg::CMD_W-1:0] outCheckWord,
  output logic [asf_pkg::CMD_W-1:0] rxWord,
  output logic [asf_pkg::WORD_IDX_W-1:0] rxWordIndex,
  output logic rxValid,
  output logic frameActive
);
  import asf_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic linkRstN;
  logic [1:0] snapLen_q, snapLen_d;
  logic [CMD_W-1:0] snapResp_q, snapResp_d;
  logic [CMD_W-1:0] snapCheck_q, snapCheck_d;
  logic [EXTRA_CNT_W-1:0] snapExtraCnt_q, snapExtraCnt_d;
  logic [MAX_EXTRA-1:0][CMD_W-1:0] snapExtra_q, snapExtra_d;
  logic [NUM_CH-1:0][ADC_W-1:0] snapCh_q, snapCh_d;
  logic [BIT_CNT_W-1:0] wordBits;
  logic [WORD_IDX_W-1:0] extraWords;
  logic [BIT_CNT_W-1:0] rxBitCnt_q, rxBitCnt_d;
  logic [WORD_IDX_W-1:0] rxWordCnt_q, rxWordCnt_d;
  logic [31:0] rxShift_q, rxShift_d;
  logic [31:0] rxFull;
  logic rxWordEnd;
  logic [CMD_W-1:0] rxHold_q, rxHold_d;
  logic [WORD_IDX_W-1:0] rxIdxHold_q, rxIdxHold_d;
  logic rxToggle_q, rxToggle_d;
  logic readToggle_q, readToggle_d;
  logic [BIT_CNT_W-1:0] txBitCnt_q, txBitCnt_d;
  logic [WORD_IDX_W-1:0] txWordCnt_q, txWordCnt_d;
  logic [WORD_IDX_W-1:0] txExtraPos;
  logic [31:0] txWord;
  logic [4:0] txBitPos;
  logic txBit_q, txBit_d;
  logic csAct1_q, csAct2_q;
  logic rxT1_q, rxT2_q, rxT3_q;
  logic rdT1_q, rdT2_q, rdT3_q;
  logic [CMD_W-1:0] rxWord_q, rxWord_d;
  logic [WORD_IDX_W-1:0] rxIdx_q, rxIdx_d;
  logic rxValid_q, rxValid_d;
  asf_ready_if rdyIf ();

  // Conversion word for the selected length; left-aligned except WLEN_32_SIGN, which is sign-extended and right-aligned
  function automatic logic [31:0] fmtAdc(input logic [ADC_W-1:0] d, input logic [1:0] len);
    logic [31:0] w;
    w = {d, 8'h00};
    if (len == WLEN_16) begin
      w = {d[ADC_W-1:8], 16'h0000};
    end else if (len == WLEN_32_SIGN) begin
      w = {{8{d[ADC_W-1]}}, d};
    end
    return w;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Core-side snapshot, frozen while a frame is active
  // Limitation: chip select must lead the first clock by three core cycles
  always_comb begin
    snapLen_d = snapLen_q;
    snapResp_d = snapResp_q;
    snapCheck_d = snapCheck_q;
    snapExtraCnt_d = snapExtraCnt_q;
    snapExtra_d = snapExtra_q;
    snapCh_d = snapCh_q;
    if (!csAct2_q) begin
      snapLen_d = wordLengthSel;
      snapResp_d = respWord;
      snapCheck_d = outCheckWord;
      snapExtraCnt_d = respExtraCount;
      if (respExtraCount > EXTRA_CNT_W'(MAX_EXTRA)) begin
        snapExtraCnt_d = EXTRA_CNT_W'(MAX_EXTRA);
      end
      snapExtra_d = respExtraWords;
      for (int i = 0; i < NUM_CH; i++) begin
        snapCh_d[i] = chanEnable[i] ? chanData[i] : '0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      snapLen_q <= WLEN_24;
      snapResp_q <= '0;
      snapCheck_q <= '0;
      snapExtraCnt_q <= '0;
      snapExtra_q <= '0;
      snapCh_q <= '0;
    end else begin
      snapLen_q <= snapLen_d;
      snapResp_q <= snapResp_d;
      snapCheck_q <= snapCheck_d;
      snapExtraCnt_q <= snapExtraCnt_d;
      snapExtra_q <= snapExtra_d;
      snapCh_q <= snapCh_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: chip select high holds the serial logic in reset
  assign linkRstN = nrst & ~csN;

  // Frame geometry from the frozen snapshot
  always_comb begin
    unique case (snapLen_q)
      WLEN_16: wordBits = BITS_16;
      WLEN_24: wordBits = BITS_24;
      WLEN_32_ZERO, WLEN_32_SIGN: wordBits = BITS_32;
    endcase
    extraWords = WORD_IDX_W'(snapExtraCnt_q);
  end

  // Receive counters on falling edges
  always_comb begin
    rxFull = {rxShift_q[30:0], din};
    rxWordEnd = (rxBitCnt_q == wordBits - 1'b1);
    rxShift_d = rxFull;
    rxBitCnt_d = rxBitCnt_q + 1'b1;
    rxWordCnt_d = rxWordCnt_q;
    if (rxWordEnd) begin
      rxBitCnt_d = '0;
      if (rxWordCnt_q != '1) begin
        rxWordCnt_d = rxWordCnt_q + 1'b1;
      end
    end
  end

  always_ff @(negedge sclk or negedge linkRstN) begin
    if (!linkRstN) begin
      rxBitCnt_q <= '0;
      rxWordCnt_q <= '0;
      rxShift_q <= '0;
    end else begin
      rxBitCnt_q <= rxBitCnt_d;
      rxWordCnt_q <= rxWordCnt_d;
      rxShift_q <= rxShift_d;
    end
  end

  // Completed words; toggles survive chip select so no event is faked
  always_comb begin
    rxHold_d = rxHold_q;
    rxIdxHold_d = rxIdxHold_q;
    rxToggle_d = rxToggle_q;
    readToggle_d = readToggle_q;
    if (rxWordEnd) begin
      unique case (snapLen_q)
        WLEN_16: rxHold_d = rxFull[15:0];
        WLEN_24: rxHold_d = rxFull[23:8];
        WLEN_32_ZERO, WLEN_32_SIGN: rxHold_d = rxFull[31:16];
      endcase
      rxIdxHold_d = rxWordCnt_q;
      rxToggle_d = ~rxToggle_q;
      if (rxWordCnt_q == extraWords + 8'h02) begin
        readToggle_d = ~readToggle_q;
      end
    end
  end

  always_ff @(negedge sclk or negedge nrst) begin
    if (!nrst) begin
      rxHold_q <= '0;
      rxIdxHold_q <= '0;
      rxToggle_q <= 1'b0;
      readToggle_q <= 1'b0;
    end else begin
      rxHold_q <= rxHold_d;
      rxIdxHold_q <= rxIdxHold_d;
      rxToggle_q <= rxToggle_d;
      readToggle_q <= readToggle_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit word select: response, extras, channels, check, then zeros
  always_comb begin
    txWord = '0;
    txExtraPos = txWordCnt_q - 8'h01;
    if (txWordCnt_q == '0) begin
      txWord = {snapResp_q, 16'h0000};
    end else if (txWordCnt_q <= extraWords) begin
      txWord = {snapExtra_q[txExtraPos[EXTRA_IDX_W-1:0]], 16'h0000};
    end else if (txWordCnt_q == extraWords + 8'h01) begin
      txWord = fmtAdc(snapCh_q[0], snapLen_q);
    end else if (txWordCnt_q == extraWords + 8'h02) begin
      txWord = fmtAdc(snapCh_q[1], snapLen_q);
    end else if (txWordCnt_q == extraWords + 8'h03) begin
      txWord = {snapCheck_q, 16'h0000};
    end
  end

  // Bit launch on rising edges, MSB first
  always_comb begin
    txBitPos = 5'h1F - txBitCnt_q[4:0];
    txBit_d = txWord[txBitPos];
    txBitCnt_d = txBitCnt_q + 1'b1;
    txWordCnt_d = txWordCnt_q;
    if (txBitCnt_q == wordBits - 1'b1) begin
      txBitCnt_d = '0;
      if (txWordCnt_q != '1) begin
        txWordCnt_d = txWordCnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge sclk or negedge linkRstN) begin
    if (!linkRstN) begin
      txBitCnt_q <= '0;
      txWordCnt_q <= '0;
      txBit_q <= 1'b0;
    end else begin
      txBitCnt_q <= txBitCnt_d;
      txWordCnt_q <= txWordCnt_d;
      txBit_q <= txBit_d;
    end
  end

  // Serial output released whenever chip select is high
  assign dout = txBit_q;
  assign doutOeN = csN;

  ////////////////////////////////////////////////////////////////////////////
  // Crossings into the core domain: two stages, third for the edge
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      csAct1_q <= 1'b0;
      csAct2_q <= 1'b0;
      rxT1_q <= 1'b0;
      rxT2_q <= 1'b0;
      rxT3_q <= 1'b0;
      rdT1_q <= 1'b0;
      rdT2_q <= 1'b0;
      rdT3_q <= 1'b0;
    end else begin
      csAct1_q <= ~csN;
      csAct2_q <= csAct1_q;
      rxT1_q <= rxToggle_q;
      rxT2_q <= rxT1_q;
      rxT3_q <= rxT2_q;
      rdT1_q <= readToggle_q;
      rdT2_q <= rdT1_q;
      rdT3_q <= rdT2_q;
    end
  end

  // Received words; hold is stable for a whole word after its toggle
  always_comb begin
    rxValid_d = rxT2_q ^ rxT3_q;
    rxWord_d = rxWord_q;
    rxIdx_d = rxIdx_q;
    if (rxValid_d) begin
      rxWord_d = rxHold_q;
      rxIdx_d = rxIdxHold_q;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rxWord_q <= '0;
      rxIdx_q <= '0;
      rxValid_q <= 1'b0;
    end else begin
      rxWord_q <= rxWord_d;
      rxIdx_q <= rxIdx_d;
      rxValid_q <= rxValid_d;
    end
  end

  assign rxWord = rxWord_q;
  assign rxWordIndex = rxIdx_q;
  assign rxValid = rxValid_q;
  assign frameActive = csAct2_q;

  ////////////////////////////////////////////////////////////////////////////
  // Ready output generator
  assign rdyIf.chanNewData = chanNewData;
  assign rdyIf.chanEnable = chanEnable;
  assign rdyIf.chanPhase = channelPhaseCal;
  assign rdyIf.osrSel = oversamplingRatio;
  assign rdyIf.globalChop = globalChop;
  assign rdyIf.syncPulse = syncPulse;
  assign rdyIf.sourceSel = readySourceSelect;
  assign rdyIf.idleFloat = readyIdleFloat;
  assign rdyIf.pulseFormat = readyPulseFormat;
  assign rdyIf.readDone = rdT2_q ^ rdT3_q;

  asf_ready_gen uReady (
    .core_clk(core_clk),
    .nrst(nrst),
    .rdy(rdyIf.gen)
  );

  assign dataReadyN = rdyIf.readyN;
  assign dataReadyOeN = rdyIf.readyOeN;
endmodule
